/* rtl/mau_consts.svh */
// Constants of the memory access unit: address map, widths and reset values.
// Assumes inclusion by the design file by bare name.
`ifndef MAU_CONSTS_SVH
`define MAU_CONSTS_SVH
`define MAU_ADDR_W        24
`define MAU_IO_BASE       24'hffe000
`define MAU_RSV_TOP       24'h00006f
`define MAU_OPT_BASE      24'h000000
`define MAU_RST_VEC       24'h000004
`define MAU_EXC_VEC       24'h000008
`define MAU_RSV_SLOT      24'h00000c
`define MAU_IRQ_VEC       24'h000010
`define MAU_NVM_TOP_DEF   24'h00ffff
`define MAU_RAM_BASE_DEF  24'hff8000
`define MAU_RAM_TOP_DEF   24'hffbfff
`define MAU_UNMAP_BYTE    8'hff
`define MAU_IO_MAP_W      13
`endif

/* rtl/mau_pkg.sv */
// Types shared by the memory access unit.
// Assumes mau_consts.svh sits beside this file.
package mau_pkg;
   typedef enum logic [1:0] {
      MAU_SIZE_B = 2'h0,
      MAU_SIZE_W = 2'h1,
      MAU_SIZE_Q = 2'h2
   } mau_size_e;
   typedef enum logic [1:0] {
      MAU_TGT_NVM = 2'h0,
      MAU_TGT_RAM = 2'h1,
      MAU_TGT_IO  = 2'h2,
      MAU_TGT_EXT = 2'h3
   } mau_tgt_e;
   typedef enum logic [2:0] {
      MAU_ST_IDLE = 3'h1,
      MAU_ST_BUS  = 3'h2,
      MAU_ST_DONE = 3'h4
   } mau_st_e;
endpackage

/* rtl/mau_access_unit.sv */
// Memory access unit: decodes the 24-bit space and splits CPU operations into bus accesses.
// Assumes one target bus handshake (req/ack) shared by all regions, selected by mem_tgt.
`timescale 1ns/1ps
`include "mau_consts.svh"

// How it works
// (R1) Requests decode on 24 address bits in one space for code, data and I/O.
// (R2) Addresses claimed by no internal region go to the external bus.
// (R3) The block from address zero is reserved for option bits and vectors.
// (R4) Slots: option bits, reset, exception, reserved, then interrupt vectors.
// (R5) The top 8 KB of the space decodes as internal I/O.
// (R6) Reads of unimplemented I/O addresses return all-ones bytes.
// (R7) Writes to unimplemented I/O addresses are dropped with no effect.
// (R8) Software never reads write-only nor writes read-only I/O registers.
// (R9) Software relies on nothing from absent external addresses.
// (R10) Multibyte data is big endian; the operand address holds the MSB.
// (R11) Target data paths may be 8 or 16 bits wide.
// (R12) Internal nonvolatile memory and RAM use 16-bit paths.
// (R13) Peripheral accesses follow the peripheral's own 8 or 16-bit width.
// (R14) The external bus width is set to 8 or 16 bits.
// (R15) Even address on 16-bit memory: word one access, quad two.
// (R16) Odd address on 16-bit memory: word two accesses, quad three.
// (R17) Short 16-bit addresses are sign extended to 24 bits.
// (R18) On 8-bit memory each byte takes one access, MSB first, ascending.
// (R19) The requester stalls until all accesses finish, then gets assembled data.
module mau_access_unit
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    cpu_req,
   input  wire logic                    cpu_we,
   input  wire logic                    cpu_short,
   input  wire logic [31:0]             cpu_addr,
   input  wire mau_pkg::mau_size_e      cpu_size,
   input  wire logic [31:0]             cpu_wdata,
   output logic                         cpu_busy,
   output logic                         cpu_done,
   output logic [31:0]                  cpu_rdata,
   input  wire logic [23:0]             nvm_top,
   input  wire logic [23:0]             ram_base,
   input  wire logic [23:0]             ram_top,
   input  wire logic                    ext_wide,
   input  wire logic                    io_wide,
   input  wire logic                    io_hit,
   output logic                         mem_req,
   output logic                         mem_we,
   output mau_pkg::mau_tgt_e            mem_tgt,
   output logic [23:0]                  mem_addr,
   output logic [1:0]                   mem_be,
   output logic [15:0]                  mem_wdata,
   input  wire logic                    mem_ack,
   input  wire logic [15:0]             mem_rdata,
   output logic                         rsv_hit,
   output logic [2:0]                   rsv_slot
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      mau_pkg::mau_st_e  st;
      logic              we;
      logic              wide;
      mau_pkg::mau_tgt_e tgt;
      logic [23:0]       addr;
      logic [2:0]        left;
      logic [31:0]       wbuf;
      logic [31:0]       rbuf;
      logic              done;
   } mau_state_s;

   mau_state_s st_r;
   mau_state_s st_nxt;

   logic [23:0]       eff_addr;
   mau_pkg::mau_tgt_e dec_tgt;
   logic              dec_wide;
   logic [2:0]        nbytes;
   logic [2:0]        step;
   logic [15:0]       rd_hw;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   always_comb
   begin
      // Short addresses reach the lowest and the highest 32 KB.
      if (cpu_short)
      begin
         eff_addr = {{8{cpu_addr[15]}}, cpu_addr[15:0]}; // R17
      end
      else
      begin
         eff_addr = cpu_addr[`MAU_ADDR_W-1:0]; // R1
      end
      if (eff_addr >= `MAU_IO_BASE)
      begin
         dec_tgt  = mau_pkg::MAU_TGT_IO; // R5
         dec_wide = io_wide; // R13
      end
      else if (eff_addr <= nvm_top)
      begin
         dec_tgt  = mau_pkg::MAU_TGT_NVM; // R3
         dec_wide = 1'b1; // R12
      end
      else if (eff_addr >= ram_base && eff_addr <= ram_top)
      begin
         dec_tgt  = mau_pkg::MAU_TGT_RAM;
         dec_wide = 1'b1; // R12
      end
      else
      begin
         dec_tgt  = mau_pkg::MAU_TGT_EXT; // R2
         dec_wide = ext_wide; // R14
      end
      case (cpu_size)
         mau_pkg::MAU_SIZE_W: nbytes = 3'h2;
         mau_pkg::MAU_SIZE_Q: nbytes = 3'h4;
         default:             nbytes = 3'h1;
      endcase
   end

   // Reserved vector block slot of the current request, for the fetch logic.
   always_comb
   begin
      rsv_hit  = (eff_addr <= `MAU_RSV_TOP) && (`MAU_RSV_TOP < nvm_top); // R3
      if (eff_addr >= `MAU_IRQ_VEC)
      begin
         rsv_slot = 3'h4; // R4
      end
      else
      begin
         rsv_slot = {1'b0, eff_addr[3:2]}; // R4
      end
   end

   // ----------------------------------------------------------------
   // Access sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      // A 16-bit path moves two bytes only from an even address with at least two left.
      if (st_r.wide && !st_r.addr[0] && st_r.left >= 3'h2) // R11
      begin
         step = 3'h2; // R15
      end
      else
      begin
         step = 3'h1; // R16 R18
      end
      // Unimplemented I/O reads as all-ones on both byte lanes.
      rd_hw = (st_r.tgt == mau_pkg::MAU_TGT_IO && !io_hit) ?
              {`MAU_UNMAP_BYTE, `MAU_UNMAP_BYTE} : mem_rdata; // R6
      case (st_r.st)
         mau_pkg::MAU_ST_IDLE:
         begin
            if (cpu_req)
            begin
               st_nxt.st   = mau_pkg::MAU_ST_BUS;
               st_nxt.we   = cpu_we;
               st_nxt.wide = dec_wide;
               st_nxt.tgt  = dec_tgt;
               st_nxt.addr = eff_addr;
               st_nxt.left = nbytes;
               // Left-justify so the MSB leaves first from the operand address.
               st_nxt.wbuf = cpu_wdata << (6'(4 - nbytes) * 6'h08); // R10
               st_nxt.rbuf = 32'h0;
            end
         end
         mau_pkg::MAU_ST_BUS:
         begin
            if (mem_ack)
            begin
               if (step == 3'h2)
               begin
                  st_nxt.rbuf = {st_r.rbuf[15:0], rd_hw}; // R10
                  st_nxt.wbuf = {st_r.wbuf[15:0], 16'h0};
               end
               else
               begin
                  st_nxt.rbuf = {st_r.rbuf[23:0], st_r.addr[0] ? rd_hw[7:0] : rd_hw[15:8]}; // R10
                  st_nxt.wbuf = {st_r.wbuf[23:0], 8'h0};
               end
               st_nxt.addr = st_r.addr + 24'(step); // R18
               st_nxt.left = st_r.left - step;
               if (st_r.left == step)
               begin
                  st_nxt.st = mau_pkg::MAU_ST_DONE; // R19
               end
            end
         end
         mau_pkg::MAU_ST_DONE:
         begin
            st_nxt.st   = mau_pkg::MAU_ST_IDLE;
            st_nxt.done = 1'b1; // R19
         end
         default:
         begin
            st_nxt.st = mau_pkg::MAU_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_r    <= '0;
         st_r.st <= mau_pkg::MAU_ST_IDLE;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      mem_req  = (st_r.st == mau_pkg::MAU_ST_BUS);
      // The register lookup follows the address on the bus, so every access of a split write is judged alone.
      mem_we   = st_r.we && !((st_r.tgt == mau_pkg::MAU_TGT_IO) && !io_hit); // R7
      mem_tgt  = st_r.tgt;
      mem_addr = st_r.addr;
      // Byte lane: even address is the upper lane of a 16-bit word.
      if (step == 3'h2)
      begin
         mem_be    = 2'h3;
         mem_wdata = st_r.wbuf[31:16];
      end
      else
      begin
         mem_be    = st_r.addr[0] ? 2'h1 : 2'h2;
         mem_wdata = {st_r.wbuf[31:24], st_r.wbuf[31:24]};
      end
      cpu_busy  = (st_r.st != mau_pkg::MAU_ST_IDLE); // R19
      cpu_done  = st_r.done;
      cpu_rdata = st_r.rbuf;
   end

endmodule

/* test/mau_access_monitor.sv */
// Assertions on the ports of the memory access unit.
// Assumes one clock and the active-high asynchronous reset.
`timescale 1ns/1ps
module mau_access_monitor
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              cpu_req,
   input wire logic              cpu_short,
   input wire logic [31:0]       cpu_addr,
   input wire logic              cpu_busy,
   input wire logic [23:0]       nvm_top,
   input wire logic [23:0]       ram_base,
   input wire logic [23:0]       ram_top,
   input wire logic              io_hit,
   input wire logic              mem_req,
   input wire logic              mem_we,
   input wire mau_pkg::mau_tgt_e mem_tgt,
   input wire logic [23:0]       mem_addr,
   input wire logic [1:0]        mem_be,
   input wire logic              mem_ack,
   input wire logic              rsv_hit,
   input wire logic [2:0]        rsv_slot
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire tk = cpu_req && !cpu_busy && !cpu_short;
   property p_take; cpu_req && !cpu_busy |=> cpu_busy; endproperty
   a_take: assert property (p_take) else $error("request not taken");
   property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we); endproperty
   a_hold: assert property (p_hold) else $error("access dropped early");
   property p_io; mem_req |-> (mem_tgt == mau_pkg::MAU_TGT_IO) == (mem_addr >= 24'hffe000); endproperty
   a_io: assert property (p_io) else $error("io decode");
   property p_ext; mem_req && mem_addr < 24'hffe000 && mem_addr > nvm_top
      && (mem_addr < ram_base || mem_addr > ram_top) |-> mem_tgt == mau_pkg::MAU_TGT_EXT; endproperty
   a_ext: assert property (p_ext) else $error("external decode");
   property p_rsv; tk |-> rsv_hit == (cpu_addr[23:0] < 24'h000070); endproperty
   a_rsv: assert property (p_rsv) else $error("reserved block");
   property p_slot; tk && cpu_addr[23:0] < 24'h000070
      |-> rsv_slot == (cpu_addr[6:4] != 3'h0 ? 3'h4 : {1'b0, cpu_addr[3:2]}); endproperty
   a_slot: assert property (p_slot) else $error("reserved slot");
   property p_pair; mem_req && mem_be == 2'h3 |-> !mem_addr[0]; endproperty
   a_pair: assert property (p_pair) else $error("odd pair access");
   property p_drop; mem_req && mem_tgt == mau_pkg::MAU_TGT_IO && !io_hit |-> !mem_we; endproperty
   a_drop: assert property (p_drop) else $error("empty io written");
endmodule
bind mau_access_unit mau_access_monitor mau_access_monitor_i (.clk(clk), .rst(rst), .cpu_req(cpu_req),
   .cpu_short(cpu_short), .cpu_addr(cpu_addr), .cpu_busy(cpu_busy), .nvm_top(nvm_top), .ram_base(ram_base),
   .ram_top(ram_top), .io_hit(io_hit), .mem_req(mem_req), .mem_we(mem_we), .mem_tgt(mem_tgt),
   .mem_addr(mem_addr), .mem_be(mem_be), .mem_ack(mem_ack), .rsv_hit(rsv_hit), .rsv_slot(rsv_slot));

/* test/mau_mem_model.sv */
// Memories and peripherals behind the access unit, 16-bit lanes, big endian.
// Assumes each access is held until the acknowledge is sampled.
`timescale 1ns/1ps
module mau_mem_model
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [23:0] mem_addr,
   input  wire logic [1:0]  mem_be,
   input  wire logic [15:0] mem_wdata,
   output logic             mem_ack,
   output logic [15:0]      mem_rdata,
   output logic             io_hit
);
   logic [7:0] mem [int];
   logic [1:0] wait_r;
   int         ev;
   wire        go = mem_req && !mem_ack && (!slow || wait_r == 2'h3);
   // Only the lower half of the I/O region holds registers.
   assign io_hit = !mem_addr[12];
   function automatic logic [7:0] rd(input int ad);
      return mem.exists(ad) ? mem[ad] : 8'(ad ^ (ad >> 8) ^ 8'h3c);
   endfunction
   // Every address answers, so no access sees an absent device.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         {mem_ack, wait_r, mem_rdata} <= 19'h0;
      end
      else
      begin
         wait_r <= wait_r + 2'h1;
         mem_ack <= go;
         mem_rdata <= ~mem_rdata;
         if (go)
         begin
            ev = {mem_addr[23:1], 1'b0};
            mem_rdata <= {rd(ev), rd(ev + 1)};
            if (mem_we && mem_be[1]) mem[ev] = mem_wdata[15:8];
            if (mem_we && mem_be[0]) mem[ev + 1] = mem_wdata[7:0];
         end
      end
   end
endmodule

/* test/testbench.sv */
// Random accesses over every region, checked against a byte-array reference.
// Assumes the design, its package, checker and memory model compile first.
`timescale 1ns/1ps
module testbench;
   logic               clk, rst, cpu_req, cpu_we, cpu_short, cpu_busy, cpu_done, ext_wide, io_wide, io_hit;
   logic               slow, mem_req, mem_we, mem_ack, rsv_hit;
   logic [31:0]        cpu_addr, cpu_wdata, cpu_rdata, want, r, s;
   logic [23:0]        mem_addr;
   logic [15:0]        mem_wdata, mem_rdata;
   logic [2:0]         rsv_slot;
   logic [1:0]         mem_be;
   logic [7:0]         mirror [int];
   mau_pkg::mau_size_e cpu_size;
   mau_pkg::mau_tgt_e  mem_tgt;
   integer             errors = 0, checked = 0, cyc = 0, n_acc = 0, seed = 32'h9393, a, n, k, i, wide, gap;
   integer             tgt_exp = 0;
   mau_access_unit mau_access_unit_i (.clk(clk), .rst(rst), .cpu_req(cpu_req), .cpu_we(cpu_we),
      .cpu_short(cpu_short), .cpu_addr(cpu_addr), .cpu_size(cpu_size), .cpu_wdata(cpu_wdata),
      .cpu_busy(cpu_busy), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .nvm_top(24'h00ffff),
      .ram_base(24'hff8000), .ram_top(24'hffbfff), .ext_wide(ext_wide), .io_wide(io_wide), .io_hit(io_hit),
      .mem_req(mem_req), .mem_we(mem_we), .mem_tgt(mem_tgt), .mem_addr(mem_addr), .mem_be(mem_be),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rsv_hit(rsv_hit), .rsv_slot(rsv_slot));
   mau_mem_model mau_mem_model_i (.clk(clk), .rst(rst), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .io_hit(io_hit));
   function automatic logic [7:0] rd(input int ad);
      return mirror.exists(ad) ? mirror[ad] : 8'(ad ^ (ad >> 8) ^ 8'h3c);
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp_v);
      checked++;
      if (seen !== exp_v)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp_v, seen);
      end
   endtask
   task print_verdict;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (mem_req && mem_ack)
      begin
         n_acc++;
         check("target", mem_tgt, tgt_exp);
         check("io drop", mem_we && mem_addr >= 24'hffe000 && mem_addr[12], 0);
      end
      if (cyc == 20000)
      begin
         errors++;
         print_verdict;
      end
   end
   initial
   begin
      {cpu_req, cpu_we, cpu_short, ext_wide, io_wide, slow, cpu_addr, cpu_wdata} = 70'h0;
      cpu_size = mau_pkg::MAU_SIZE_B;
      rst = 1'b1;
      repeat (12) @(negedge clk);
      check("reset", {cpu_busy, cpu_done, mem_req}, 0);
      rst = 1'b0;
      repeat (300)
      begin
         r = $random(seed);
         s = $random(seed);
         case (r[30:29])
            2'h0: a = r[7:0];
            2'h1: a = 24'hff8000 | r[13:0];
            2'h2: a = 24'hffe000 | r[12:0];
            default: a = 24'h100000 | r[19:0];
         endcase
         if (r[31])
            a = {{8{r[15]}}, r[15:0]};
         a = a & 24'hfffff7;
         cpu_addr = r[31] ? {r[28:13], a[15:0]} : {r[28:21], a[23:0]};
         cpu_short = r[31];
         {slow, io_wide, ext_wide, cpu_we} = s[3:0];
         cpu_wdata = $random(seed);
         n = s[5:4] == 2'h3 ? 4 : 1 << s[5:4];
         cpu_size = mau_pkg::mau_size_e'(n == 4 ? 2 : n - 1);
         wide = a >= 24'hffe000 ? io_wide : (a >= 24'hff8000 && a <= 24'hffbfff) || a <= 24'h00ffff ? 1 : ext_wide;
         tgt_exp = a >= 24'hffe000 ? 2 : a <= 24'h00ffff ? 0 : a >= 24'hff8000 && a <= 24'hffbfff ? 1 : 3;
         {k, i, want} = 96'h0;
         while (i < n)
         begin
            i += (wide && (a + i) % 2 == 0 && n - i > 1) ? 2 : 1;
            k++;
         end
         for (int j = 0; j < n; j++)
         begin
            want = want << 8 | (a >= 24'hffe000 && a[12] ? 8'hff : rd(a + j));
            if (cpu_we && !(a >= 24'hffe000 && a[12]))
               mirror[a + j] = 8'(cpu_wdata >> 8 * (n - 1 - j));
         end
         cpu_req = 1'b1;
         n_acc = 0;
         @(negedge clk);
         cpu_req = 1'b0;
         check("busy", cpu_busy, 1);
         check("reserved", rsv_hit, a <= 24'h00006f);
         if (a <= 24'h00006f)
            check("slot", rsv_slot, a >= 24'h000010 ? 4 : a[3:2]);
         for (gap = 0; gap < 99 && cpu_done !== 1'b1; gap++)
            @(negedge clk);
         check("done", cpu_done, 1);
         check("accesses", n_acc, k);
         if (!cpu_we)
            check("rdata", cpu_rdata & (n == 4 ? 32'hffffffff : (32'h1 << 8 * n) - 1), want);
         @(negedge clk);
      end
      print_verdict;
   end
endmodule
